// ### design/dbp_dual_byte_bidir_port.sv
// Two 8-bit bidirectional ports with latches and direction registers behind AXI4-Lite.
// Functional notes
// - First port is eight bits wide with one output latch bit per pin.
// - Second port is eight bits wide with one output latch bit per pin.
// - Reset leaves both port data latches untouched.
// - Reset clears both direction registers, so every pin starts as input.
// - Direction one drives the latch onto the pin; zero leaves it undriven.
// - Reading a port returns the latch for pins whose direction is one.
// - Reading a port returns the sampled pin level for pins whose direction is zero.
// - Latch writes always land, whatever the direction, without touching the sensed input.
// - Five-bit converter channel select decides which second-port pin the converter owns.
// - A converter-owned pin reads zero as input, latch value as output.
// - On converter-owned pins direction only picks the read source, not the driver.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module dbp_dual_byte_bidir_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dbp_pkg::dbp_axil_req_t axil_req,
  output dbp_pkg::dbp_axil_rsp_t axil_rsp,
  input wire logic [7:0] first_port_pin_in,
  output dbp_pkg::dbp_pin_drive_t first_port_drive,
  input wire logic [7:0] second_port_pin_in,
  output dbp_pkg::dbp_pin_drive_t second_port_drive
);
  import dbp_pkg::*;

  // Per-bit read source; a converter-owned input bit reads zero.
  function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin, input logic [7:0] owned);
    port_read = (dir & latch) | (~dir & ~owned & pin);
  endfunction

  // Turns a byte address into a register index; misaligned addresses map nowhere.
  function automatic logic [8:0] addr_index(input logic [DBP_ADDR_W-1:0] addr);
    addr_index = {addr[1:0] != 2'h0, 2'h0, addr[DBP_ADDR_W-1:2]};
  endfunction

  // True for the register indices that the map decodes; only the write decode uses it, the read decode has its own case.
  function automatic logic reg_mapped(input logic [8:0] idx);
    case (idx)
      {1'b0, DBP_IDX_FIRST_LATCH}, {1'b0, DBP_IDX_SECOND_LATCH},
      {1'b0, DBP_IDX_FIRST_DIR}, {1'b0, DBP_IDX_SECOND_DIR},
      {1'b0, DBP_IDX_CONV_SEL}: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  // One-hot map of the second-port pin that a converter select value claims, if any.
  function automatic logic [7:0] owned_map(input logic active, input logic [4:0] ch);
    owned_map = 8'h00;
    if (active && ch < DBP_CONV_PORT_CHANNELS) begin
      owned_map[ch[2:0]] = 1'b1;
    end
  endfunction

  // Bus state.
  logic aw_have_ff;
  logic nxt_aw_have;
  logic w_have_ff;
  logic nxt_w_have;
  logic [DBP_ADDR_W-1:0] aw_addr_ff;
  logic [DBP_ADDR_W-1:0] nxt_aw_addr;
  logic [31:0] w_data_ff;
  logic [31:0] nxt_w_data;
  logic w_strb0_ff;
  logic nxt_w_strb0;
  dbp_axil_rsp_t rsp_ff;
  dbp_axil_rsp_t nxt_rsp;

  // Register state.
  logic [7:0] first_latch_ff;
  logic [7:0] nxt_first_latch;
  logic [7:0] second_latch_ff;
  logic [7:0] nxt_second_latch;
  logic [7:0] first_dir_ff;
  logic [7:0] nxt_first_dir;
  logic [7:0] second_dir_ff;
  logic [7:0] nxt_second_dir;
  logic [4:0] conv_ch_ff;
  logic [4:0] nxt_conv_ch;
  logic conv_active_ff;
  logic nxt_conv_active;

  // Pin state.
  logic [7:0] first_sync1_ff;
  logic [7:0] nxt_first_sync1;
  logic [7:0] first_sync2_ff;
  logic [7:0] nxt_first_sync2;
  logic [7:0] second_sync1_ff;
  logic [7:0] nxt_second_sync1;
  logic [7:0] second_sync2_ff;
  logic [7:0] nxt_second_sync2;
  dbp_pin_drive_t first_drive_ff;
  dbp_pin_drive_t nxt_first_drive;
  dbp_pin_drive_t second_drive_ff;
  dbp_pin_drive_t nxt_second_drive;

  logic do_write;
  logic [8:0] wr_idx;
  logic [8:0] rd_idx;
  logic [7:0] conv_owned;
  logic [7:0] nxt_conv_owned;

  assign do_write = aw_have_ff && w_have_ff && !rsp_ff.bvalid;
  assign wr_idx = addr_index(aw_addr_ff);
  assign rd_idx = addr_index(axil_req.araddr);

  // Reads use the select value in force; the drive uses the one being written, so a newly
  // claimed pin is released at the same edge as the select register changes.
  assign conv_owned = owned_map(conv_active_ff, conv_ch_ff);
  assign nxt_conv_owned = owned_map(nxt_conv_active, nxt_conv_ch);

  // Bus next-state logic.
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb0 = w_strb0_ff;
    nxt_rsp = rsp_ff;

    // Write address channel.
    if (rsp_ff.awready && axil_req.awvalid) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = axil_req.awaddr;
    end

    // Write data channel.
    if (rsp_ff.wready && axil_req.wvalid) begin
      nxt_w_have = 1'b1;
      nxt_w_data = axil_req.wdata;
      nxt_w_strb0 = axil_req.wstrb[0];
    end

    // Write response channel; a new response wins over the release of the old one.
    if (rsp_ff.bvalid && axil_req.bready) begin
      nxt_rsp.bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_rsp.bvalid = 1'b1;
      if (reg_mapped(wr_idx)) begin
        nxt_rsp.bresp = DBP_RESP_OKAY;
      end else begin
        nxt_rsp.bresp = DBP_RESP_SLVERR;
      end
    end
    nxt_rsp.awready = !nxt_aw_have && !nxt_rsp.bvalid;
    nxt_rsp.wready = !nxt_w_have && !nxt_rsp.bvalid;

    // Read channels; one read is under way at a time, so arready is simply the inverse of rvalid.
    if (rsp_ff.rvalid && axil_req.rready) begin
      nxt_rsp.rvalid = 1'b0;
    end
    if (rsp_ff.arready && axil_req.arvalid) begin
      nxt_rsp.rvalid = 1'b1;
      nxt_rsp.rresp = DBP_RESP_OKAY;
      nxt_rsp.rdata = 32'h0000_0000;
      case (rd_idx)
        {1'b0, DBP_IDX_FIRST_LATCH}: begin
          nxt_rsp.rdata[7:0] = port_read(first_latch_ff, first_dir_ff, first_sync2_ff, 8'h00);
        end
        {1'b0, DBP_IDX_SECOND_LATCH}: begin
          nxt_rsp.rdata[7:0] = port_read(second_latch_ff, second_dir_ff, second_sync2_ff,
                                         conv_owned);
        end
        {1'b0, DBP_IDX_FIRST_DIR}: nxt_rsp.rdata[7:0] = first_dir_ff;
        {1'b0, DBP_IDX_SECOND_DIR}: nxt_rsp.rdata[7:0] = second_dir_ff;
        {1'b0, DBP_IDX_CONV_SEL}: begin
          nxt_rsp.rdata[DBP_CONV_CH_LSB +: 5] = conv_ch_ff;
          nxt_rsp.rdata[DBP_CONV_ACTIVE_BIT] = conv_active_ff;
        end
        default: nxt_rsp.rresp = DBP_RESP_SLVERR;
      endcase
    end
    nxt_rsp.arready = !nxt_rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      rsp_ff <= nxt_rsp;
    end
  end

  // Register next-state logic; only byte lane 0 carries data.
  always_comb begin
    nxt_first_latch = first_latch_ff;
    nxt_second_latch = second_latch_ff;
    nxt_first_dir = first_dir_ff;
    nxt_second_dir = second_dir_ff;
    nxt_conv_ch = conv_ch_ff;
    nxt_conv_active = conv_active_ff;
    if (do_write && w_strb0_ff) begin
      case (wr_idx)
        {1'b0, DBP_IDX_FIRST_LATCH}: nxt_first_latch = w_data_ff[7:0];
        {1'b0, DBP_IDX_SECOND_LATCH}: nxt_second_latch = w_data_ff[7:0];
        {1'b0, DBP_IDX_FIRST_DIR}: nxt_first_dir = w_data_ff[7:0];
        {1'b0, DBP_IDX_SECOND_DIR}: nxt_second_dir = w_data_ff[7:0];
        {1'b0, DBP_IDX_CONV_SEL}: begin
          nxt_conv_ch = w_data_ff[DBP_CONV_CH_LSB +: 5];
          nxt_conv_active = w_data_ff[DBP_CONV_ACTIVE_BIT];
        end
        default: nxt_conv_ch = conv_ch_ff;
      endcase
    end
  end

  // The data latches keep their contents across reset, so they sit outside the reset branch.
  always_ff @(posedge aclk) begin
    first_latch_ff <= nxt_first_latch;
    second_latch_ff <= nxt_second_latch;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_dir_ff <= DBP_DIR_RESET;
      second_dir_ff <= DBP_DIR_RESET;
    end else begin
      first_dir_ff <= nxt_first_dir;
      second_dir_ff <= nxt_second_dir;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_ch_ff <= DBP_CONV_CH_RESET;
      conv_active_ff <= DBP_CONV_ACTIVE_RESET;
    end else begin
      conv_ch_ff <= nxt_conv_ch;
      conv_active_ff <= nxt_conv_active;
    end
  end

  // Pin drive: a converter-owned pin is released no matter what its direction bit says.
  always_comb begin
    nxt_first_drive.out = nxt_first_latch;
    nxt_first_drive.oe = nxt_first_dir;
    nxt_second_drive.out = nxt_second_latch;
    nxt_second_drive.oe = nxt_second_dir & ~nxt_conv_owned;
  end

  // Pins are asynchronous to aclk; the first stage feeds only the second.
  always_comb begin
    nxt_first_sync1 = first_port_pin_in;
    nxt_first_sync2 = first_sync1_ff;
    nxt_second_sync1 = second_port_pin_in;
    nxt_second_sync2 = second_sync1_ff;
  end

  always_ff @(posedge aclk) begin
    first_sync1_ff <= nxt_first_sync1;
    first_sync2_ff <= nxt_first_sync2;
    second_sync1_ff <= nxt_second_sync1;
    second_sync2_ff <= nxt_second_sync2;
  end

  // Loading the drive from the nxt_ values updates the pin in the same cycle as the registers,
  // so the pin is never one cycle behind the register.
  // The driven value is kept through reset like the latch; only the enables are cleared.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_drive_ff.oe <= 8'h00;
      first_drive_ff.out <= nxt_first_drive.out;
    end else begin
      first_drive_ff <= nxt_first_drive;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_drive_ff.oe <= 8'h00;
      second_drive_ff.out <= nxt_second_drive.out;
    end else begin
      second_drive_ff <= nxt_second_drive;
    end
  end

  assign axil_rsp = rsp_ff;
  assign first_port_drive = first_drive_ff;
  assign second_port_drive = second_drive_ff;
endmodule

// ### design/dbp_pkg.sv
// Package with the register map, field layout and bus carriers of the dual byte port.
package dbp_pkg;
  localparam int unsigned DBP_ADDR_W = 8;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] DBP_IDX_FIRST_LATCH = 8'h00;
  localparam logic [7:0] DBP_IDX_SECOND_LATCH = 8'h01;
  localparam logic [7:0] DBP_IDX_FIRST_DIR = 8'h04;
  localparam logic [7:0] DBP_IDX_SECOND_DIR = 8'h05;
  localparam logic [7:0] DBP_IDX_CONV_SEL = 8'h08;
  localparam logic [7:0] DBP_DIR_RESET = 8'h00;
  localparam logic [4:0] DBP_CONV_CH_RESET = 5'h00;
  localparam logic DBP_CONV_ACTIVE_RESET = 1'b0;
  // Converter select register layout: channel in bits 4:0, active flag in bit 7.
  localparam int unsigned DBP_CONV_CH_LSB = 0;
  localparam int unsigned DBP_CONV_ACTIVE_BIT = 7;
  // Channels below this value land on the second port's pins.
  localparam logic [4:0] DBP_CONV_PORT_CHANNELS = 5'h08;
  localparam logic [1:0] DBP_RESP_OKAY = 2'h0;
  localparam logic [1:0] DBP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [DBP_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [DBP_ADDR_W-1:0] araddr;
    logic rready;
  } dbp_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dbp_axil_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dbp_pin_drive_t;
endpackage

// ### test/dbp_port_props.sv
// Checker with concurrent assertions on the dual byte port.
`timescale 1ns/1ps
module dbp_port_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dbp_pkg::dbp_axil_req_t axil_req,
  input wire dbp_pkg::dbp_axil_rsp_t axil_rsp,
  input wire dbp_pkg::dbp_pin_drive_t first_port_drive,
  input wire dbp_pkg::dbp_pin_drive_t second_port_drive
);
  import dbp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  assign wr_go = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    && axil_req.wstrb[0];
  property p_lands(logic [7:0] a, logic [7:0] obs);
    logic [7:0] v;
    (wr_go && axil_req.awaddr == a, v = axil_req.wdata[7:0]) |-> ##2 obs == v;
  endproperty
  property p_owned;
    logic [2:0] ch;
    (wr_go && axil_req.awaddr == 8'h20 && axil_req.wdata[7] && axil_req.wdata[4:0] < 5'h08,
      ch = axil_req.wdata[2:0]) |-> ##2 !second_port_drive.oe[ch];
  endproperty
  a_first_latch_out: assert property (p_lands(8'h00, first_port_drive.out))
    else $error("first port drive value does not follow latch write");
  a_second_latch_out: assert property (p_lands(8'h04, second_port_drive.out))
    else $error("second port drive value does not follow latch write");
  a_first_dir_oe: assert property (p_lands(8'h10, first_port_drive.oe))
    else $error("first port enables do not follow direction write");
  a_second_dir_oe: assert property (p_lands(8'h14, second_port_drive.oe))
    else $error("second port enables do not follow direction write");
  a_owned_pin_off: assert property (p_owned)
    else $error("converter pin still driven");
  a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read answer late");
  a_rdata_upper: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_dir_reset: assert property (disable iff (1'b0) !aresetn |=>
    first_port_drive.oe == 8'h00 && second_port_drive.oe == 8'h00)
    else $error("pins driven after reset");
  a_latch_keep: assert property (disable iff (1'b0) aresetn ##1 !aresetn |=>
    first_port_drive.out == $past(first_port_drive.out, 2))
    else $error("latch changed by reset");
  c_write: cover property (wr_go);
  c_read_err: cover property (axil_rsp.rvalid && axil_rsp.rresp == DBP_RESP_SLVERR);
  c_write_err: cover property (axil_rsp.bvalid && axil_rsp.bresp == DBP_RESP_SLVERR);
endmodule
bind dbp_dual_byte_bidir_port dbp_port_props u_props (.aclk(aclk), .aresetn(aresetn),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .first_port_drive(first_port_drive),
  .second_port_drive(second_port_drive));

// ### test/dbp_pin_model.sv
// Model of the circuitry wired to one port's pins.
`timescale 1ns/1ps
module dbp_pin_model (
  input dbp_pkg::dbp_pin_drive_t drive,
  input logic [7:0] ext,
  output logic [7:0] pin
);
  import dbp_pkg::*;
  // The outside source drives only released pins, so the wire never sees a fight.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = drive.oe[i] ? drive.out[i] : ext[i];
    end
  end
endmodule

// ### test/test_dual_byte_bidir_port.sv
// Bench that drives the port over its register bus and checks reads and pin drive.
`timescale 1ns/1ps
module test_dual_byte_bidir_port;
  import dbp_pkg::*;
  localparam logic [7:0] A_L1 = DBP_IDX_FIRST_LATCH << 2;
  localparam logic [7:0] A_L2 = DBP_IDX_SECOND_LATCH << 2;
  localparam logic [7:0] A_D1 = DBP_IDX_FIRST_DIR << 2;
  localparam logic [7:0] A_D2 = DBP_IDX_SECOND_DIR << 2;
  localparam logic [7:0] A_SEL = DBP_IDX_CONV_SEL << 2;
  logic aclk, aresetn;
  dbp_axil_req_t req;
  dbp_axil_rsp_t rsp;
  dbp_pin_drive_t drv1, drv2;
  logic [7:0] pin1, pin2, ext1, ext2;
  int mismatches = 0;
  int tests_run = 0;
  dbp_dual_byte_bidir_port u_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .first_port_pin_in(pin1), .first_port_drive(drv1),
    .second_port_pin_in(pin2), .second_port_drive(drv2));
  dbp_pin_model u_pins1 (.drive(drv1), .ext(ext1), .pin(pin1));
  dbp_pin_model u_pins2 (.drive(drv2), .ext(ext2), .pin(pin2));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check("bresp", {6'h00, rsp.bresp}, {6'h00, er});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    check("rdata", rsp.rdata[7:0], e);
    check("rresp", {6'h00, rsp.rresp}, {6'h00, er});
  endtask
  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    complete_run;
  end
  initial begin
    req = '0;
    req.wstrb = 4'hF;
    aresetn = 1'b0;
    ext1 = 8'h3C;
    ext2 = 8'hFF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(A_D1, 8'h00, DBP_RESP_OKAY);
    rdchk(A_D2, 8'h00, DBP_RESP_OKAY);
    wr(A_L1, 8'hA5, DBP_RESP_OKAY);
    rdchk(A_L1, 8'h3C, DBP_RESP_OKAY);
    check("out1", drv1.out, 8'hA5);
    // The latch is loaded before the pins are turned into outputs.
    wr(A_D1, 8'hF0, DBP_RESP_OKAY);
    rdchk(A_L1, 8'hAC, DBP_RESP_OKAY);
    check("oe1", drv1.oe, 8'hF0);
    ext1 <= 8'hC3;
    repeat (3) @(posedge aclk);
    rdchk(A_L1, 8'hA3, DBP_RESP_OKAY);
    wr(A_L2, 8'h5A, DBP_RESP_OKAY);
    wr(A_D2, 8'h0F, DBP_RESP_OKAY);
    rdchk(A_L2, 8'hFA, DBP_RESP_OKAY);
    wr(A_SEL, 8'h85, DBP_RESP_OKAY);
    rdchk(A_L2, 8'hDA, DBP_RESP_OKAY);
    wr(A_SEL, 8'h83, DBP_RESP_OKAY);
    rdchk(A_L2, 8'hFA, DBP_RESP_OKAY);
    check("oe2", drv2.oe, 8'h07);
    wr(A_SEL, 8'h03, DBP_RESP_OKAY);
    check("oe2", drv2.oe, 8'h0F);
    wr(8'h30, 8'h11, DBP_RESP_SLVERR);
    rdchk(8'h30, 8'h00, DBP_RESP_SLVERR);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("out1", drv1.out, 8'hA5);
    check("out2", drv2.out, 8'h5A);
    check("oe2", drv2.oe, 8'h00);
    rdchk(A_D2, 8'h00, DBP_RESP_OKAY);
    complete_run;
  end
endmodule
